//--- core/pps_top.v
// Switching-cycle control and protection sequencer of the converter
`timescale 1ns/1ps
`default_nettype none
`include "pps_regs.vh"

module pps_top #(
  parameter PERIOD_CYC = 500,
  parameter OS_CYC = `PPS_OS_CYC,
  parameter OL_CYC = `PPS_OL_CYC,
  parameter HIC_CYC = `PPS_HIC_CYC,
  parameter SS_STEP_CYC = `PPS_SS_STEP,
  parameter FBW = 8,
  parameter SSW = 8
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_n_i,
  // Supervisory inputs
  input wire enable_i,
  input wire undervoltage_lockout_i,
  input wire ctrl_hot_i,
  input wire pd_hot_i,
  // Mode configuration
  input wire psr_mode_i,
  input wire [1:0] dead_sel_i,
  // Comparator inputs and feedback code
  input wire cs_over_comp_i,
  input wire cs_over_limit_i,
  input wire cs_over_short_i,
  input wire cs_below_floor_i,
  input wire comp_at_psm_i,
  input wire comp_at_switch_i,
  input wire fb_over_ovp_i,
  input wire [FBW-1:0] fb_code_i,
  // Drives
  output reg gate_o,
  output reg sync_rect_o,
  // Feedback path and soft-start
  output reg fb_sample_o,
  output reg [FBW-1:0] fb_held_o,
  output reg ea_en_o,
  output reg comp_pullup_o,
  output reg [SSW-1:0] ss_level_o,
  output reg ss_clamp_o,
  output reg ss_done_o,
  // Status
  output reg hiccup_o,
  output reg pd_off_o
);

  // ****************************************
  // Constants and state codes
  // ****************************************
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_HIC = 3'b100;
  // Integer forms first, then cut to counter width on purpose
  localparam integer PER_MAX_I = `PPS_MINF_CYC;
  localparam integer MAX_ON_I = PERIOD_CYC * `PPS_MAXDUTY_PCT / 100;
  localparam integer LEB_I = `PPS_LEB_CYC;
  localparam integer FBBLK_I = `PPS_FBBLK_CYC;
  localparam integer OL_LAST_I = OL_CYC - 1;
  localparam integer HIC_LAST_I = HIC_CYC - 1;
  localparam integer SS_LAST_I = SS_STEP_CYC - 1;
  localparam [12:0] PER_NOM = PERIOD_CYC[12:0];
  localparam [12:0] PER_MAX = PER_MAX_I[12:0];
  localparam [12:0] MAX_ON = MAX_ON_I[12:0];
  localparam [12:0] LEB_CYC = LEB_I[12:0];
  localparam [12:0] FBBLK_CYC = FBBLK_I[12:0];
  localparam [12:0] OS_LOAD = OS_CYC[12:0];
  localparam [19:0] OL_LAST = OL_LAST_I[19:0];
  localparam [25:0] HIC_LAST = HIC_LAST_I[25:0];
  localparam [15:0] SS_LAST = SS_LAST_I[15:0];
  localparam [SSW-1:0] SS_FULL = {SSW{1'b1}};

  // ****************************************
  // Reset release
  // ****************************************
  reg rst_m_r;
  reg rst_s_r;
  wire rst_n;

  // Two-stage release so downstream logic leaves reset on a clean edge
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end
    else
    begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end
  end
  assign rst_n = rst_s_r;

  // ****************************************
  // Declarations and decode
  // ****************************************
  reg [2:0] state_r;
  reg psr_r;
  reg [1:0] dt_r;
  reg [12:0] cyc_cnt_r;
  reg [12:0] period_r;
  reg [12:0] on_cnt_r;
  reg [12:0] off_cnt_r;
  reg [12:0] os_cnt_r;
  reg [19:0] ol_cnt_r;
  reg [25:0] hic_cnt_r;
  reg [15:0] ss_div_r;
  reg [5:0] dt_cnt_r;
  reg gate_req_r;
  reg low_pk_r;

  wire run = (state_r == ST_RUN);
  // Interface overheat stops everything, controller overheat only us
  wire stop = !enable_i | undervoltage_lockout_i | ctrl_hot_i | pd_hot_i;
  wire cyc_start = run & (cyc_cnt_r == period_r - 13'h0001);
  wire sense_ok = gate_o & (on_cnt_r >= LEB_CYC);
  // Floor holds the pulse only in primary-side mode
  wire floor_hold = psr_r & cs_below_floor_i;
  wire comp_end = sense_ok & cs_over_comp_i & !floor_hold;
  wire lim_end = sense_ok & cs_over_limit_i;
  // Request drops one edge before the gate, so end two counts early
  wire duty_end = gate_o & (on_cnt_r >= MAX_ON - 13'h0002);
  wire short_trip = sense_ok & cs_over_short_i;
  wire fb_tick = run & !gate_o & (off_cnt_r == FBBLK_CYC);
  wire ovp_trip = fb_tick & fb_over_ovp_i;
  wire ol_trip = (ol_cnt_r == OL_LAST);
  wire trip = run & (short_trip | ovp_trip | ol_trip);
  wire [5:0] dt_lim = ({4'h0, dt_r} + 6'h01) * `PPS_DT_STEP;

  // ****************************************
  // Sequencer state
  // ****************************************
  // Hiccup restart simply re-enters run; a lingering fault trips again
  always @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      psr_r <= 1'b0;
      dt_r <= 2'h0;
      hic_cnt_r <= 26'h0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          psr_r <= psr_mode_i;
          dt_r <= dead_sel_i;
          if (!stop)
            state_r <= ST_RUN;
        end
        ST_RUN:
        begin
          hic_cnt_r <= 26'h0;
          if (stop)
            state_r <= ST_IDLE;
          else if (trip)
            state_r <= ST_HIC;
        end
        ST_HIC:
        begin
          hic_cnt_r <= hic_cnt_r + 26'h1;
          if (stop)
            state_r <= ST_IDLE;
          else if (hic_cnt_r == HIC_LAST)
            state_r <= ST_RUN;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Oscillator and frequency foldback
  // ****************************************
  // In primary-side mode the period stretches while peaks sit at the floor, clamped at the minimum
  always @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cyc_cnt_r <= 13'h0;
      period_r <= PER_NOM;
    end
    else if (!run)
    begin
      cyc_cnt_r <= 13'h0;
      period_r <= PER_NOM;
    end
    else if (cyc_start)
    begin
      cyc_cnt_r <= 13'h0;
      if (!psr_r)
        period_r <= PER_NOM;
      else if (low_pk_r)
        period_r <= (period_r + `PPS_FSTEP > PER_MAX) ? PER_MAX : period_r + `PPS_FSTEP;
      else
        period_r <= (period_r < PER_NOM + `PPS_FSTEP) ? PER_NOM : period_r - `PPS_FSTEP;
    end
    else
      cyc_cnt_r <= cyc_cnt_r + 13'h0001;
  end

  // ****************************************
  // Pulse request and on/off timers
  // ****************************************
  // Request only rises at cycle start, so a limit end lasts the cycle
  always @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gate_req_r <= 1'b0;
      low_pk_r <= 1'b0;
      on_cnt_r <= 13'h0;
      off_cnt_r <= 13'h0;
    end
    else
    begin
      if (!run)
        gate_req_r <= 1'b0;
      else if (cyc_start)
        gate_req_r <= psr_r | !comp_at_psm_i;
      else if (comp_end | lim_end | duty_end)
        gate_req_r <= 1'b0;
      if (gate_req_r & (comp_end | lim_end | duty_end))
        low_pk_r <= cs_below_floor_i;
      on_cnt_r <= gate_o ? on_cnt_r + 13'h0001 : 13'h0;
      if (gate_o)
        off_cnt_r <= 13'h0;
      else if (off_cnt_r <= FBBLK_CYC)
        off_cnt_r <= off_cnt_r + 13'h0001;
    end
  end

  // ****************************************
  // Gate and sync drive with dead time
  // ****************************************
  // Sync goes high (rectifier off) before gate rises, falls after gate drops
  always @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gate_o <= 1'b0;
      sync_rect_o <= 1'b0;
      dt_cnt_r <= 6'h0;
    end
    else if (!run)
    begin
      gate_o <= 1'b0;
      sync_rect_o <= 1'b0;
      dt_cnt_r <= 6'h0;
    end
    else if (gate_req_r & !short_trip)
    begin
      sync_rect_o <= 1'b1;
      if (!gate_o)
      begin
        if (dt_cnt_r == dt_lim)
        begin
          gate_o <= 1'b1;
          dt_cnt_r <= 6'h0;
        end
        else
          dt_cnt_r <= dt_cnt_r + 6'h01;
      end
    end
    else
    begin
      gate_o <= 1'b0;
      if (!sync_rect_o)
        dt_cnt_r <= 6'h0;
      else if (dt_cnt_r == dt_lim)
      begin
        sync_rect_o <= 1'b0;
        dt_cnt_r <= 6'h0;
      end
      else
        dt_cnt_r <= dt_cnt_r + 6'h01;
    end
  end

  // ****************************************
  // Overload one-shot and window
  // ****************************************
  // Window counts only while the one-shot says overcurrent persists
  always @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      os_cnt_r <= 13'h0;
      ol_cnt_r <= 20'h0;
    end
    else
    begin
      if (!run)
        os_cnt_r <= 13'h0;
      else if (lim_end)
        os_cnt_r <= OS_LOAD;
      else if (os_cnt_r != 13'h0)
        os_cnt_r <= os_cnt_r - 13'h0001;
      if (!run | !ss_done_o | (os_cnt_r == 13'h0) | ol_trip)
        ol_cnt_r <= 20'h0;
      else
        ol_cnt_r <= ol_cnt_r + 20'h1;
    end
  end

  // ****************************************
  // Soft-start ramp
  // ****************************************
  // Any stop or trip discharges the ramp so each restart is soft
  always @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ss_level_o <= {SSW{1'b0}};
      ss_div_r <= 16'h0;
      ss_done_o <= 1'b0;
      ss_clamp_o <= 1'b0;
    end
    else if (!run | trip)
    begin
      ss_level_o <= {SSW{1'b0}};
      ss_div_r <= 16'h0;
      ss_done_o <= 1'b0;
      ss_clamp_o <= 1'b0;
    end
    else
    begin
      ss_done_o <= psr_r ? (ss_level_o == SS_FULL) : comp_at_switch_i | (ss_level_o == SS_FULL);
      ss_clamp_o <= !psr_r & !ss_done_o;
      if (!ss_done_o & (ss_level_o != SS_FULL))
      begin
        if (ss_div_r == SS_LAST)
        begin
          ss_div_r <= 16'h0;
          ss_level_o <= ss_level_o + {{(SSW-1){1'b0}}, 1'b1};
        end
        else
          ss_div_r <= ss_div_r + 16'h1;
      end
    end
  end

  // ****************************************
  // Feedback sample, amplifier mode, status
  // ****************************************
  always @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fb_sample_o <= 1'b0;
      fb_held_o <= {FBW{1'b0}};
      ea_en_o <= 1'b0;
      comp_pullup_o <= 1'b0;
      hiccup_o <= 1'b0;
      pd_off_o <= 1'b0;
    end
    else
    begin
      fb_sample_o <= fb_tick & psr_r;
      if (fb_tick & psr_r)
        fb_held_o <= fb_code_i;
      ea_en_o <= psr_r;
      comp_pullup_o <= !psr_r;
      hiccup_o <= (state_r == ST_HIC);
      pd_off_o <= pd_hot_i;
    end
  end

endmodule
`default_nettype wire

//--- inc/pps_regs.vh
// Timing and threshold constants for the PWM protection sequencer
`ifndef PPS_REGS_VH
`define PPS_REGS_VH

// ****************************************
// Clock and switching timing
// ****************************************
`define PPS_CLK_NS 8
`define PPS_MINF_PER_NS 33333
`define PPS_MINF_CYC (`PPS_MINF_PER_NS / `PPS_CLK_NS)
`define PPS_MAXDUTY_PCT 70
`define PPS_FSTEP 13'h0010
`define PPS_LEB_NS 250
`define PPS_LEB_CYC ((`PPS_LEB_NS + `PPS_CLK_NS - 1) / `PPS_CLK_NS)
`define PPS_FBBLK_NS 300
`define PPS_FBBLK_CYC ((`PPS_FBBLK_NS + `PPS_CLK_NS - 1) / `PPS_CLK_NS)
`define PPS_DT_STEP 6'h08

// ****************************************
// Protection timing
// ****************************************
`define PPS_OS_NS 50000
`define PPS_OS_CYC (`PPS_OS_NS / `PPS_CLK_NS)
`define PPS_OL_NS 4800000
`define PPS_OL_CYC (`PPS_OL_NS / `PPS_CLK_NS)
`define PPS_HIC_MS 340
`define PPS_HIC_CYC (`PPS_HIC_MS * 1000000 / `PPS_CLK_NS)
`define PPS_SS_STEP 16000

`endif

//--- verif/pps_checker.sv
// Port-level checker for the PWM protection sequencer
`timescale 1ns/1ps
`default_nettype none
module pps_checker #(
  parameter FBW = 8,
  parameter SSW = 8
) (
  // Clock, reset, supervisory inputs and short-circuit comparator
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic undervoltage_lockout_i,
  input wire logic ctrl_hot_i,
  input wire logic pd_hot_i,
  input wire logic cs_over_short_i,
  // Observed outputs
  input wire logic gate_o,
  input wire logic sync_rect_o,
  input wire logic fb_sample_o,
  input wire logic [FBW-1:0] fb_held_o,
  input wire logic ea_en_o,
  input wire logic comp_pullup_o,
  input wire logic [SSW-1:0] ss_level_o,
  input wire logic ss_done_o,
  input wire logic hiccup_o,
  input wire logic pd_off_o
);
  // ****
  // Helpers
  // ****
  // Edges since release; the reset synchroniser hides the first few
  logic [1:0] rc_r;
  logic [8:0] on_r;
  wire stop_w = !enable_i || undervoltage_lockout_i || ctrl_hot_i || pd_hot_i;
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
    if (!rst_n_i)
      rc_r <= 2'h0;
    else if (rc_r != 2'h3)
      rc_r <= rc_r + 2'h1;
  // Length of the running gate pulse
  always_ff @(posedge sys_clk_i)
    on_r <= gate_o ? on_r + 9'h1 : 9'h0;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i || rc_r != 2'h3);
  // ****
  // Assertions
  // ****
  AST_STOP_OFF: assert property (stop_w |-> ##3 !gate_o && !sync_rect_o)
    else $error("drives still on after stop");
  AST_GATE_SYNC: assert property (gate_o |-> sync_rect_o)
    else $error("gate on while rectifier on");
  AST_DEAD: assert property ($rose(gate_o) |-> $past(sync_rect_o, 8))
    else $error("dead time too short");
  AST_DUTY: assert property (on_r <= 9'h15e)
    else $error("gate pulse over max duty");
  AST_LEB: assert property ($fell(gate_o) && !$past(stop_w, 2) |-> on_r >= 9'h20)
    else $error("pulse ended inside blanking");
  AST_SHORT: assert property (cs_over_short_i && on_r > 9'h28 |=> !gate_o)
    else $error("gate stayed on at short");
  AST_FB_SAMPLE: assert property (fb_sample_o |-> ea_en_o && !$past(gate_o, 30))
    else $error("feedback sampled too early");
  AST_FB_HOLD: assert property (!fb_sample_o |-> $stable(fb_held_o))
    else $error("held feedback moved");
  AST_MODE: assert property (ss_done_o |-> ea_en_o != comp_pullup_o)
    else $error("amplifier and pull-up disagree");
  AST_HIC: assert property (hiccup_o |-> !gate_o && ss_level_o == '0)
    else $error("ramp or gate live in hiccup");
  AST_PD_OFF: assert property (pd_off_o == $past(pd_hot_i))
    else $error("interface stop mismatch");
  // Main scenarios reached
  cover property ($rose(hiccup_o));
  cover property (fb_sample_o);
  cover property ($fell(gate_o) && on_r < 9'h28);
endmodule
bind pps_top pps_checker #(.FBW(FBW), .SSW(SSW)) u_pps_chk (
  .sys_clk_i, .rst_n_i, .enable_i, .undervoltage_lockout_i, .ctrl_hot_i, .pd_hot_i,
  .cs_over_short_i, .gate_o, .sync_rect_o, .fb_sample_o, .fb_held_o,
  .ea_en_o, .comp_pullup_o, .ss_level_o, .ss_done_o, .hiccup_o, .pd_off_o);
`default_nettype wire

//--- verif/pps_far_model.sv
// Behavioural power stage seen through the sense comparators
`timescale 1ns/1ps
`default_nettype none
module pps_far_model (
  // Clock and gate drive
  input wire logic sys_clk_i,
  input wire logic gate_i,
  // Levels set by the bench
  input wire logic [7:0] comp_lvl_i,
  input wire logic [7:0] lim_lvl_i,
  input wire logic [7:0] short_lvl_i,
  input wire logic ovp_i,
  // Comparator outputs and feedback code
  output logic cs_over_comp_o,
  output logic cs_over_limit_o,
  output logic cs_over_short_o,
  output logic cs_below_floor_o,
  output logic comp_at_switch_o,
  output logic fb_over_ovp_o,
  output logic [7:0] fb_code_o
);
  // ****
  // Primary current ramp
  // ****
  logic [7:0] ramp_r = 8'h00;
  logic [7:0] peak_r = 8'h00;
  // Current climbs while the switch conducts, saturating at full scale
  always_ff @(posedge sys_clk_i)
  begin
    ramp_r <= !gate_i ? 8'h00 : (ramp_r == 8'hff ? ramp_r : ramp_r + 8'h01);
    peak_r <= gate_i ? ramp_r : peak_r;
  end
  // Aux winding is negative while on, so feedback is scrambled then
  always_comb
  begin
    cs_over_comp_o = ramp_r > comp_lvl_i;
    cs_over_limit_o = ramp_r > lim_lvl_i;
    cs_over_short_o = ramp_r > short_lvl_i;
    cs_below_floor_o = ramp_r < 8'h10;
    comp_at_switch_o = comp_lvl_i > 8'h20;
    fb_over_ovp_o = ovp_i && !gate_i;
    fb_code_o = gate_i ? ~peak_r : peak_r;
  end
endmodule
`default_nettype wire

//--- verif/test_pwm_protection_sequencer.sv
// Self-checking bench for the PWM protection sequencer
`timescale 1ns/1ps
`default_nettype none
module test_pwm_protection_sequencer;
  // ****
  // Stimulus and wiring
  // ****
  typedef struct packed {logic primary_side_regulation; logic [1:0] ds; logic [7:0] dt;} pps_row_t;
  // Dead time grows by eight cycles per select code
  pps_row_t rows [4] = '{'{1'b0, 2'h0, 8'h08}, '{1'b1, 2'h1, 8'h10},
    '{1'b0, 2'h3, 8'h20}, '{1'b1, 2'h2, 8'h18}};
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic enable_i = 1'b1;
  logic undervoltage_lockout_i = 1'b0;
  logic ctrl_hot_i = 1'b0;
  logic pd_hot_i = 1'b0;
  logic psr_mode_i = 1'b1;
  logic [1:0] dead_sel_i = 2'h0;
  logic [7:0] comp_lvl = 8'h40;
  logic [7:0] lim_lvl = 8'hff;
  logic [7:0] short_lvl = 8'hff;
  logic overvoltage_shutdown = 1'b0;
  logic power_save_floor = 1'b0;
  wire cs_over_comp_i, cs_over_limit_i, cs_over_short_i, cs_below_floor_i;
  wire comp_at_switch_i, fb_over_ovp_i, gate_o, sync_rect_o, fb_sample_o;
  wire ea_en_o, comp_pullup_o, ss_clamp_o, ss_done_o, hiccup_o, pd_off_o;
  wire [7:0] fb_code_i, fb_held_o, ss_level_o;
  int num_errors = 0;
  int cmp_count = 0;
  int n;
  logic k;
  always #4 sys_clk_i = ~sys_clk_i;
  // Short counts keep hiccup and soft-start within a brief run
  // One-shot outlasts a period so repeated limit ends build an overload
  pps_top #(.OS_CYC(600), .OL_CYC(1200), .HIC_CYC(100), .SS_STEP_CYC(4)) DUT (
    .sys_clk_i, .rst_n_i, .enable_i, .undervoltage_lockout_i, .ctrl_hot_i, .pd_hot_i,
    .psr_mode_i, .dead_sel_i, .cs_over_comp_i, .cs_over_limit_i,
    .cs_over_short_i, .cs_below_floor_i, .comp_at_psm_i(power_save_floor), .comp_at_switch_i,
    .fb_over_ovp_i, .fb_code_i, .gate_o, .sync_rect_o, .fb_sample_o, .fb_held_o,
    .ea_en_o, .comp_pullup_o, .ss_level_o, .ss_clamp_o, .ss_done_o, .hiccup_o,
    .pd_off_o);
  pps_far_model far (
    .sys_clk_i, .gate_i(gate_o), .comp_lvl_i(comp_lvl), .lim_lvl_i(lim_lvl),
    .short_lvl_i(short_lvl), .ovp_i(overvoltage_shutdown), .cs_over_comp_o(cs_over_comp_i),
    .cs_over_limit_o(cs_over_limit_i), .cs_over_short_o(cs_over_short_i),
    .cs_below_floor_o(cs_below_floor_i), .comp_at_switch_o(comp_at_switch_i),
    .fb_over_ovp_o(fb_over_ovp_i), .fb_code_o(fb_code_i));
  // Verdict and run end
  task print_verdict;
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Compare and report
  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (e !== g)
    begin
      $display("unexpected %s exp %h got %h", s, e, g);
      num_errors++;
    end
  endtask
  // Signal picker for the bounded wait
  function logic sg(input int w);
    case (w)
      0: sg = gate_o;
      1: sg = sync_rect_o;
      2: sg = hiccup_o;
      default: sg = fb_sample_o;
    endcase
  endfunction
  // Bounded wait for a level; n holds the cycles taken
  task wt(input int w, input logic v);
    n = 0;
    while (sg(w) !== v)
    begin
      @(negedge sys_clk_i);
      n++;
      if (n > 2000)
      begin
        chk("wait", 8'h01, 8'h00);
        print_verdict;
      end
    end
  endtask
  // Mode and dead time are only taken while idle, so stop first
  task rs(input logic p, input logic [1:0] d);
    enable_i = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    psr_mode_i = p;
    dead_sel_i = d;
    enable_i = 1'b1;
  endtask
  // ****
  // Main sequence
  // ****
  initial
  begin
    repeat (12) @(negedge sys_clk_i);
    chk("reset", 8'h00, 8'({gate_o, sync_rect_o, hiccup_o, ss_done_o}));
    rst_n_i = 1'b1;
    foreach (rows[i])
    begin
      rs(rows[i].primary_side_regulation, rows[i].ds);
      wt(1, 1'b1);
      wt(0, 1'b1);
      chk("dead_on", rows[i].dt, n[7:0]);
      chk("ea_en", 8'(rows[i].primary_side_regulation), 8'(ea_en_o));
      chk("pullup", 8'(!rows[i].primary_side_regulation), 8'(comp_pullup_o));
      wt(0, 1'b0);
      wt(1, 1'b0);
      chk("dead_off", rows[i].dt, n[7:0]);
    end
    wt(3, 1'b1);
    chk("fb_held", fb_code_i, fb_held_o);
    $display("test modes done");
    comp_lvl = 8'h00;
    wt(0, 1'b1);
    wt(0, 1'b0);
    chk("leb", 8'h01, 8'(n >= 32 && n <= 36));
    comp_lvl = 8'hff;
    lim_lvl = 8'h64;
    repeat (2)
    begin
      wt(0, 1'b1);
      wt(0, 1'b0);
      chk("limit", 8'h01, 8'(n >= 100 && n <= 106));
      k = 1'b0;
      repeat (300)
      begin
        @(negedge sys_clk_i);
        k = k | gate_o;
      end
      chk("limit_hold", 8'h00, 8'(k));
    end
    lim_lvl = 8'hff;
    wt(0, 1'b1);
    wt(0, 1'b0);
    chk("duty", 8'h01, 8'(n >= 300 && n <= 350));
    chk("ol_resume", 8'h00, 8'(hiccup_o));
    lim_lvl = 8'h64;
    wt(2, 1'b1);
    chk("ol_trip", 8'h01, 8'(n >= 1350 && n <= 1550));
    lim_lvl = 8'hff;
    wt(2, 1'b0);
    $display("test pulse end done");
    short_lvl = 8'h50;
    wt(2, 1'b1);
    chk("hic_ss", 8'h00, ss_level_o);
    chk("hic_drv", 8'h00, 8'({gate_o, sync_rect_o}));
    wt(2, 1'b0);
    chk("hic_len", 8'h01, 8'(n >= 98 && n <= 102));
    wt(2, 1'b1);
    short_lvl = 8'hff;
    wt(2, 1'b0);
    overvoltage_shutdown = 1'b1;
    wt(2, 1'b1);
    overvoltage_shutdown = 1'b0;
    wt(2, 1'b0);
    wt(0, 1'b1);
    $display("test hiccup done");
    undervoltage_lockout_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    chk("undervoltage_lockout", 8'h00, 8'({gate_o, sync_rect_o}));
    undervoltage_lockout_i = 1'b0;
    pd_hot_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    chk("pd_hot", 8'h04, 8'({pd_off_o, gate_o, sync_rect_o}));
    pd_hot_i = 1'b0;
    ctrl_hot_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    chk("ctrl_hot", 8'h00, 8'({pd_off_o, gate_o, sync_rect_o}));
    ctrl_hot_i = 1'b0;
    wt(0, 1'b1);
    $display("test shutdown done");
    power_save_floor = 1'b1;
    rs(1'b0, 2'h0);
    k = 1'b0;
    repeat (1200)
    begin
      @(negedge sys_clk_i);
      k = k | sync_rect_o;
    end
    chk("psm_skip", 8'h00, 8'(k));
    power_save_floor = 1'b0;
    wt(0, 1'b1);
    $display("test power save done");
    print_verdict;
  end
endmodule
`default_nettype wire
